// file: src/uart_lms_pkg.sv
package uart_lms_pkg;

   // Register byte addresses on the APB window
   localparam logic [7:0] modem_control_addr = 8'h00;
   localparam logic [7:0] line_status_addr = 8'h04;
   localparam logic [7:0] modem_status_addr = 8'h08;
   localparam logic [7:0] turnaround_delay_addr = 8'h0c;
   localparam logic [7:0] feature_addr = 8'h10;

   // Modem control fields
   localparam int mcr_dtr_bit = 0;
   localparam int mcr_rts_bit = 1;
   localparam int mcr_fsel_bit = 2;
   localparam int mcr_aux2_bit = 3;
   localparam int mcr_loop_bit = 4;

   // Feature register fields
   localparam int feat_lsi_en_bit = 0;
   localparam int feat_msi_en_bit = 1;
   localparam int feat_enh_bit = 2;
   localparam int feat_auto_cts_bit = 3;
   localparam int feat_auto_rts_bit = 4;
   localparam int feat_rs485_bit = 5;
   localparam int feat_fifo_en_bit = 6;

   localparam logic [7:0] modem_control_rst = 8'h00;
   localparam logic [7:0] feature_rst = 8'h00;
   localparam logic [3:0] turnaround_rst = 4'h0;

   // Modem input pins, all active low
   typedef struct packed {
      logic carrier_detect_n;
      logic ring_indicate_n;
      logic set_ready_n;
      logic clear_send_n;
   } modem_in_t;

   // Status from the receive and transmit datapath, same clock
   typedef struct packed {
      logic rx_data_avail;
      logic rx_top_parity_err;
      logic rx_top_framing_err;
      logic rx_top_break;
      logic rx_fifo_any_err;
      logic rx_fifo_full;
      logic rx_char_done;
      logic rx_line_low_frame;
      logic rx_line_idle;
      logic tx_fifo_empty;
      logic tx_shift_empty;
      logic tx_load;
      logic tx_last_stop_done;
      logic bit_tick;
   } path_status_t;

endpackage

// file: src/uart_line_modem_status.sv
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Select bit picks rts/cts pair (0) or dtr/dsr pair (1) for auto flow.
// - In loopback the select bit is aux one and drives ring status.
// - Request-send pin is low when its control bit is 1; resets high.
// - Terminal-ready pin is low when its control bit is 1; resets high.
// - Line-status interrupt fires at once on any receive error if enabled.
// - FIFO error summary is 1 while any error entry remains.
// - Transmitter-empty is 1 only when fifo and shift register empty.
// - Transmit-fifo-empty tracks the transmit fifo or holding register.
// - Break flagged after a low frame, one break char, held until idle.
// - Framing error belongs to the character at fifo top.
// - Parity error belongs to the character at fifo top.
// - Char done while fifo full sets overrun and is not stored.
// - Data-ready is 1 while a received character waits; resets 0.
// - Carrier status is inverted pin, or aux two in loopback.
// - Ring status is inverted pin, or aux one in loopback.
// - Set-ready status is inverted pin, or terminal-ready bit in loopback.
// - Clear-send status is inverted pin, or request-send bit in loopback.
// - Selected input high pauses transmitter after current character.
// - Carrier, set-ready, clear-send changes set flags and may interrupt.
// - Ring change flag sets only on pin rising edge.
// - Turnaround code gives 0 to 15 bit times after last stop bit.
// - Turnaround writes accepted only while enhanced enable is set.
// - Auto rs-485 raises request-send on load, drops it after delay.
module uart_line_modem_status
(
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire uart_lms_pkg::modem_in_t modem_in,
   input wire uart_lms_pkg::path_status_t path_status,
   output logic request_send_n,
   output logic terminal_ready_n,
   output logic tx_pause,
   output logic rx_store_break,
   output logic rx_drop_char,
   output logic line_irq,
   output logic modem_irq
);
   import uart_lms_pkg::*;

   logic [7:0] modem_control_ff;
   logic [7:0] feature_ff;
   logic [3:0] turnaround_ff;
   modem_in_t pin_meta_ff;
   modem_in_t pin_sync_ff;
   modem_in_t pin_prev_ff;
   logic [3:0] delta_ff;
   logic overrun_ff;
   logic break_ff;
   logic break_loaded_ff;
   logic rs485_on_ff;
   logic [3:0] delay_cnt_ff;
   logic delay_run_ff;
   logic [7:0] status_word;
   logic [7:0] line_word;
   logic access;
   logic [3:0] nxt_delta;
   logic [3:0] delta_set;
   logic loop_mode;
   logic mapped;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      hit = (a == r);
   endfunction

   assign access = psel && penable;
   assign loop_mode = modem_control_ff[mcr_loop_bit];
   assign mapped = hit(paddr, modem_control_addr)
      || hit(paddr, line_status_addr) || hit(paddr, modem_status_addr)
      || hit(paddr, turnaround_delay_addr) || hit(paddr, feature_addr);

   // Two-stage synchroniser on the modem pins
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         pin_meta_ff <= '1;
         pin_sync_ff <= '1;
         pin_prev_ff <= '1;
      end
      else
      begin
         pin_meta_ff <= modem_in;
         pin_sync_ff <= pin_meta_ff;
         pin_prev_ff <= pin_sync_ff;
      end
   end

   // Status bits: inverted pins, or loopback of control bits
   always_comb
   begin
      status_word = 8'h00;
      if (loop_mode)
      begin
         status_word[7] = modem_control_ff[mcr_aux2_bit];
         status_word[6] = modem_control_ff[mcr_fsel_bit];
         status_word[5] = modem_control_ff[mcr_dtr_bit];
         status_word[4] = modem_control_ff[mcr_rts_bit];
      end
      else
      begin
         status_word[7] = ~pin_sync_ff.carrier_detect_n;
         status_word[6] = ~pin_sync_ff.ring_indicate_n;
         status_word[5] = ~pin_sync_ff.set_ready_n;
         status_word[4] = ~pin_sync_ff.clear_send_n;
      end
      status_word[3:0] = delta_ff;
   end

   // Change events; loopback suppresses pin changes
   always_comb
   begin
      delta_set = 4'h0;
      if (!loop_mode)
      begin
         delta_set[3] = pin_sync_ff.carrier_detect_n
            ^ pin_prev_ff.carrier_detect_n;
         delta_set[2] = pin_sync_ff.ring_indicate_n
            && !pin_prev_ff.ring_indicate_n;
         delta_set[1] = pin_sync_ff.set_ready_n
            ^ pin_prev_ff.set_ready_n;
         delta_set[0] = pin_sync_ff.clear_send_n
            ^ pin_prev_ff.clear_send_n;
      end
      nxt_delta = delta_ff;
      // Clear on the edge that captures the read word, so a change
      // arriving while the read is in flight is kept for the next read
      if (psel && !penable && !pwrite && hit(paddr, modem_status_addr))
      begin
         nxt_delta = 4'h0;
      end
      // Set wins over the read clear so no change is lost
      nxt_delta = nxt_delta | delta_set;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         delta_ff <= 4'h0;
      end
      else
      begin
         delta_ff <= nxt_delta;
      end
   end

   // Register writes
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         modem_control_ff <= modem_control_rst;
         feature_ff <= feature_rst;
         turnaround_ff <= turnaround_rst;
      end
      else if (access && pwrite)
      begin
         if (hit(paddr, modem_control_addr))
         begin
            modem_control_ff <= pwdata[7:0];
         end
         if (hit(paddr, feature_addr))
         begin
            feature_ff <= pwdata[7:0];
         end
         if (hit(paddr, turnaround_delay_addr)
            && feature_ff[feat_enh_bit])
         begin
            turnaround_ff <= pwdata[7:4];
         end
      end
   end

   // Overrun: sticky until line status read; set wins over clear
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         overrun_ff <= 1'b0;
      end
      else if (path_status.rx_char_done && path_status.rx_fifo_full)
      begin
         overrun_ff <= 1'b1;
      end
      else if (psel && !penable && !pwrite && hit(paddr, line_status_addr))
      begin
         overrun_ff <= 1'b0;
      end
   end

   // Break held until the line returns to mark
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         break_ff <= 1'b0;
         break_loaded_ff <= 1'b0;
         rx_store_break <= 1'b0;
      end
      else
      begin
         rx_store_break <= 1'b0;
         if (path_status.rx_line_idle)
         begin
            break_ff <= 1'b0;
            break_loaded_ff <= 1'b0;
         end
         else if (path_status.rx_line_low_frame)
         begin
            break_ff <= 1'b1;
            if (!break_loaded_ff)
            begin
               break_loaded_ff <= 1'b1;
               rx_store_break <= 1'b1;
            end
         end
      end
   end

   always_comb
   begin
      line_word = 8'h00;
      line_word[7] = path_status.rx_fifo_any_err;
      line_word[6] = path_status.tx_fifo_empty
         && path_status.tx_shift_empty;
      line_word[5] = path_status.tx_fifo_empty;
      line_word[4] = break_ff || path_status.rx_top_break;
      line_word[3] = path_status.rx_top_framing_err;
      line_word[2] = path_status.rx_top_parity_err;
      line_word[1] = overrun_ff;
      line_word[0] = path_status.rx_data_avail;
   end

   // Auto rs-485 direction: raise on load, drop after turnaround
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         rs485_on_ff <= 1'b0;
         delay_run_ff <= 1'b0;
         delay_cnt_ff <= 4'h0;
      end
      else if (!feature_ff[feat_rs485_bit])
      begin
         rs485_on_ff <= 1'b0;
         delay_run_ff <= 1'b0;
      end
      else if (path_status.tx_load)
      begin
         rs485_on_ff <= 1'b1;
         delay_run_ff <= 1'b0;
      end
      else if (path_status.tx_last_stop_done && path_status.tx_fifo_empty)
      begin
         if (turnaround_ff == 4'h0)
         begin
            rs485_on_ff <= 1'b0;
         end
         else
         begin
            delay_run_ff <= 1'b1;
            delay_cnt_ff <= turnaround_ff;
         end
      end
      else if (delay_run_ff && path_status.bit_tick)
      begin
         if (delay_cnt_ff == 4'h1)
         begin
            delay_run_ff <= 1'b0;
            rs485_on_ff <= 1'b0;
         end
         delay_cnt_ff <= delay_cnt_ff - 4'h1;
      end
   end

   // Pins, flow pause and interrupts, all registered
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         request_send_n <= 1'b1;
         terminal_ready_n <= 1'b1;
         tx_pause <= 1'b0;
         rx_drop_char <= 1'b0;
         line_irq <= 1'b0;
         modem_irq <= 1'b0;
      end
      else
      begin
         if (feature_ff[feat_rs485_bit])
         begin
            // Transceiver enable is active high on this pin
            request_send_n <= rs485_on_ff;
         end
         else
         begin
            request_send_n <= ~modem_control_ff[mcr_rts_bit];
         end
         terminal_ready_n <= ~modem_control_ff[mcr_dtr_bit];
         // Transmitter samples pause only between characters
         if (feature_ff[feat_auto_cts_bit] && !loop_mode)
         begin
            tx_pause <= modem_control_ff[mcr_fsel_bit]
               ? pin_sync_ff.set_ready_n
               : pin_sync_ff.clear_send_n;
         end
         else
         begin
            tx_pause <= 1'b0;
         end
         rx_drop_char <= path_status.rx_char_done
            && path_status.rx_fifo_full;
         line_irq <= feature_ff[feat_lsi_en_bit]
            && (path_status.rx_fifo_any_err || overrun_ff
            || break_ff);
         modem_irq <= feature_ff[feat_msi_en_bit]
            && (nxt_delta != 4'h0);
      end
   end

   // APB slave: zero wait states, unmapped reads zero with error
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         prdata <= 32'h0000_0000;
         if (psel && !penable && !pwrite)
         begin
            if (hit(paddr, modem_control_addr))
            begin
               prdata <= {24'h00_0000, modem_control_ff};
            end
            else if (hit(paddr, line_status_addr))
            begin
               prdata <= {24'h00_0000, line_word};
            end
            else if (hit(paddr, modem_status_addr))
            begin
               prdata <= {24'h00_0000, status_word};
            end
            else if (hit(paddr, feature_addr))
            begin
               prdata <= {24'h00_0000, feature_ff};
            end
         end
      end
   end

endmodule

`default_nettype wire

// file: bench/uart_line_modem_status_props.sv
`timescale 1ns/1ps
`default_nettype none
module uart_line_modem_status_props
import uart_lms_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire uart_lms_pkg::modem_in_t modem_in,
   input wire uart_lms_pkg::path_status_t path_status,
   input wire logic request_send_n,
   input wire logic terminal_ready_n,
   input wire logic tx_pause,
   input wire logic rx_store_break,
   input wire logic rx_drop_char,
   input wire logic line_irq,
   input wire logic modem_irq
);
   // Shadows of host writes, so pin checks need no peek inside
   logic [7:0] mcr_ff;
   logic [7:0] feat_ff;
   logic wr;
   logic known;
   assign wr = psel && penable && pwrite;
   assign known = paddr inside {modem_control_addr, line_status_addr,
      modem_status_addr, turnaround_delay_addr, feature_addr};
   always_ff @(posedge clock or posedge rst)
      if (rst)
         mcr_ff <= modem_control_rst;
      else if (wr && paddr == modem_control_addr)
         mcr_ff <= pwdata[7:0];
   always_ff @(posedge clock or posedge rst)
      if (rst)
         feat_ff <= feature_rst;
      else if (wr && paddr == feature_addr)
         feat_ff <= pwdata[7:0];
   default clocking @(posedge clock);
   endclocking
   default disable iff (rst);
   chk_ready_one: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("pready not a single access cycle");
   chk_ready_idle: assert property (!(psel && penable) |-> !pready)
      else $error("pready outside access");
   chk_unmapped_err: assert property (pready |-> pslverr == !known
      && (known || pwrite || prdata == 32'h0))
      else $error("bad error response");
   chk_dtr_pin: assert property ($stable(mcr_ff) && !mcr_ff[4]
      |-> terminal_ready_n == !mcr_ff[0])
      else $error("terminal ready pin wrong");
   chk_rts_pin: assert property ($stable(mcr_ff) && !feat_ff[5]
      && !$past(feat_ff[5]) |-> request_send_n == !mcr_ff[1])
      else $error("request send pin wrong");
   chk_loop_status: assert property (
      pready && !pwrite && paddr == modem_status_addr && mcr_ff[4]
      |-> prdata[7:4] == {mcr_ff[3], mcr_ff[2], mcr_ff[0], mcr_ff[1]})
      else $error("loopback status wrong");
   chk_drop_full: assert property (path_status.rx_char_done
      && path_status.rx_fifo_full |=> rx_drop_char)
      else $error("char into full fifo not dropped");
   chk_drop_cause: assert property (rx_drop_char
      |-> $past(path_status.rx_char_done) && $past(path_status.rx_fifo_full))
      else $error("drop without full fifo");
   chk_break_pulse: assert property (rx_store_break
      |=> !rx_store_break)
      else $error("break load longer than one cycle");
   chk_line_masked: assert property (!feat_ff[0]
      && !$past(feat_ff[0]) |-> !line_irq)
      else $error("line irq while disabled");
   chk_modem_masked: assert property (!feat_ff[1]
      && !$past(feat_ff[1]) |-> !modem_irq)
      else $error("modem irq while disabled");
endmodule
bind uart_line_modem_status uart_line_modem_status_props chk (.clock, .rst,
   .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .modem_in, .path_status, .request_send_n, .terminal_ready_n, .tx_pause,
   .rx_store_break, .rx_drop_char, .line_irq, .modem_irq);
`default_nettype wire

// file: bench/modem_far.sv
`timescale 1ns/1ps
`default_nettype none
module modem_far
import uart_lms_pkg::*;
(
   input wire logic clock,
   input wire logic [3:0] level,
   output var uart_lms_pkg::modem_in_t pins
);
   // Lines sit inactive high until the far end first acts
   // High on the selected line pauses the local sender, low resumes
   initial
   begin
      pins = 4'hf;
      forever @(posedge clock) pins <= level;
   end
endmodule
`default_nettype wire

// file: bench/uart_line_modem_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) \
   begin compares++; if ((a) !== (b)) \
   begin n_mismatch++; $display("[FAIL] %0t %s", $time, m); end end
module uart_line_modem_status_tb;
   import uart_lms_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic pready, pslverr, er, request_send_n, terminal_ready_n, tx_pause;
   logic rx_store_break, rx_drop_char, line_irq, modem_irq;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic [3:0] far = 4'hf;
   logic [3:0] prv, dl;
   logic [4:0] r;
   logic [1:0] t;
   modem_in_t modem_in;
   path_status_t ps = '0;
   int n_mismatch = 0;
   int compares = 0;
   int modem_control, i, k;
   int codes[$] = {0, 15, 3, 3};
   uart_line_modem_status uut (.clock, .rst, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .modem_in,
      .path_status(ps), .request_send_n, .terminal_ready_n, .tx_pause,
      .rx_store_break, .rx_drop_char, .line_irq, .modem_irq);
   modem_far far_end (.clock, .level(far), .pins(modem_in));
   initial
   begin
      forever #2.5 clock = ~clock;
   end
   task automatic give_verdict();
      if (n_mismatch == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // An idle cycle precedes each setup so no signal is driven twice at once
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      // Read right after the edge: these are the values sampled at it
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'b1 && n < 40);
      if (n >= 40)
      begin
         n_mismatch++;
         give_verdict();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   initial
   begin
      void'($urandom(32'hf366));
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      for (i = 0; i < 6; i++)
      begin
         modem_control = (i == 0) ? 0 : $urandom % 16;
         xfer(1'b1, modem_control_addr, modem_control);
         xfer(1'b0, modem_control_addr, 0);
         `CHK(rd[7:0], 8'(modem_control), "mcr readback")
         `CHK(request_send_n, ~modem_control[1], "request send pin")
         `CHK(terminal_ready_n, ~modem_control[0], "terminal ready pin")
      end
      xfer(1'b0, 8'h14, 0);
      `CHK({er, rd}, 33'h100000000, "unmapped read")
      for (i = 0; i < 4; i++)
      begin
         modem_control = 16 + $urandom % 16;
         xfer(1'b1, modem_control_addr, modem_control);
         xfer(1'b0, modem_status_addr, 0);
         `CHK(rd[7:6], {modem_control[3], modem_control[2]}, "loop aux")
         `CHK(rd[5:4], {modem_control[0], modem_control[1]}, "loop ctl")
      end
      xfer(1'b1, modem_control_addr, 0);
      xfer(1'b1, feature_addr, 2);
      // Flush any change seen while the pin synchronisers left reset
      xfer(1'b0, modem_status_addr, 0);
      prv = far;
      for (i = 0; i < 8; i++)
      begin
         far <= 4'($urandom);
         repeat (6) @(posedge clock);
         dl = ((prv ^ far) & 4'b1011) | (~prv & far & 4'b0100);
         `CHK(modem_irq, |dl, "modem irq")
         xfer(1'b0, modem_status_addr, 0);
         `CHK(rd[7:4], ~far, "lines")
         `CHK(rd[3:0], dl, "deltas")
         prv = far;
      end
      xfer(1'b1, feature_addr, 8);
      for (i = 0; i < 8; i++)
      begin
         xfer(1'b1, modem_control_addr, i[2] * 4);
         far <= {2'b11, 2'(i)};
         repeat (6) @(posedge clock);
         `CHK(tx_pause, i[2] ? i[1] : i[0], "pause")
      end
      xfer(1'b1, feature_addr, 1);
      for (i = 0; i < 8; i++)
      begin
         r = 5'($urandom);
         r[0] = r[0] | (|r[3:1]);
         t = 2'($urandom);
         ps <= {r, 4'b0001, t, 3'b000};
         repeat (4) @(posedge clock);
         `CHK(line_irq, r[0], "line irq")
         xfer(1'b0, line_status_addr, 0);
         `CHK(rd[7:0], {r[0], &t, t[1], r[1], r[2], r[3], 1'b0, r[4]},
            "line status")
      end
      ps <= 14'h0120;
      @(posedge clock) ps <= 14'h01a0;
      @(posedge clock) ps <= 14'h0120;
      i = 0;
      repeat (3) @(posedge clock) i += rx_drop_char;
      `CHK(i, 1, "drop pulses")
      `CHK(line_irq, 1'b1, "overrun irq")
      xfer(1'b0, line_status_addr, 0);
      `CHK(rd[1], 1'b1, "overrun")
      xfer(1'b0, line_status_addr, 0);
      `CHK(rd[1], 1'b0, "overrun cleared")
      for (k = 0; k < 2; k++)
      begin
         ps <= 14'h0040;
         i = 0;
         repeat (20) @(posedge clock) i += rx_store_break;
         `CHK(line_irq, 1'b1, "break irq")
         xfer(1'b0, line_status_addr, 0);
         `CHK(rd[4], 1'b1, "break held")
         ps <= 14'h0020;
         repeat (4) @(posedge clock) i += rx_store_break;
         `CHK(i, 1, "break loads")
         xfer(1'b0, line_status_addr, 0);
         `CHK(rd[4], 1'b0, "break ended")
      end
      xfer(1'b1, feature_addr, 36);
      for (k = 0; k < 4; k++)
      begin
         if (k == 3)
            xfer(1'b1, feature_addr, 32);
         xfer(1'b1, turnaround_delay_addr, (k == 3 ? 15 : codes[k]) << 4);
         @(posedge clock) ps <= 14'h0024;
         @(posedge clock) ps <= 14'h0030;
         repeat (3) @(posedge clock);
         `CHK(request_send_n, 1'b1, "rs485 raise")
         @(posedge clock) ps <= 14'h003a;
         @(posedge clock) ps <= 14'h0038;
         for (i = 0; i < codes[k]; i++)
         begin
            repeat (2) @(posedge clock);
            `CHK(request_send_n, 1'b1, "turnaround hold")
            @(posedge clock) ps <= 14'h0039;
            @(posedge clock) ps <= 14'h0038;
         end
         repeat (3) @(posedge clock);
         `CHK(request_send_n, 1'b0, "rs485 drop")
      end
      give_verdict();
   end
endmodule
`default_nettype wire
